// [common/fft_pkg.sv]
// Shared constants and types for the FIFO flag and cascade-token blocks
package fft_pkg;
   localparam int          FFT_DEPTH     = 1024;
   localparam int          FFT_DW        = 18;
   localparam int          FFT_CTRL_W    = 12;
   // Control bits forced high by enhanced-mode reset
   localparam int          FFT_ENH_BITS  = 6;
   localparam int          FFT_CB_PAF    = 4;
   localparam int          FFT_CB_HF_HI  = 3;
   localparam int          FFT_CB_HF_LO  = 2;
   // Enable-pulse dividers for write and read beats
   localparam int          FFT_WDIV      = 2;
   localparam int          FFT_RDIV      = 3;
   // Host register map, byte addresses
   localparam logic [7:0]  FFT_A_CTRL    = 8'h00;
   localparam logic [7:0]  FFT_A_WDATA   = 8'h04;
   localparam logic [7:0]  FFT_A_RDATA   = 8'h08;
   localparam logic [7:0]  FFT_A_STATUS  = 8'h0C;
   // Host control register fields
   localparam int          FFT_C_MRST    = 0;
   localparam int          FFT_C_ENHANCED_MODE_SELECT_N = 1;
   localparam int          FFT_C_FLOAD   = 2;
   localparam int          FFT_C_WXI     = 3;
   localparam int          FFT_C_RXI     = 4;
   localparam int          FFT_C_W       = 5;

   typedef enum logic [1:0] {
      FFT_STANDALONE = 2'b00,
      FFT_PARALLEL   = 2'b01,
      FFT_MASTER     = 2'b11,
      FFT_SLAVE      = 2'b10
   } fft_group_e;

   typedef logic [FFT_DW-1:0] fft_word_t;
   typedef logic [FFT_CTRL_W-1:0] fft_ctrl_t;
endpackage : fft_pkg

// [common/fft_link_if.sv]
// Pin-level link between the FIFO device and its surrounding system logic
interface fft_link_if;
   import fft_pkg::*;
   logic      master_reset_n;
   logic      wclk_en;
   logic      rclk_en;
   logic      wr_en_n;
   logic      rd_en_n;
   fft_word_t data_in;
   fft_word_t data_output_bus;
   logic      write_token_in_or_second_write_enable;
   logic      read_token_in_or_second_read_enable;
   logic      first_load_or_replay;
   logic      enhanced_mode_select;
   logic      full_flag_n;
   logic      almost_full_flag_n;
   logic      empty_flag_n;
   logic      write_token_out_or_half_full;
   logic      read_token_out_or_second_empty;

   modport dev (
      input  master_reset_n, wclk_en, rclk_en, wr_en_n, rd_en_n, data_in,
      input  write_token_in_or_second_write_enable, read_token_in_or_second_read_enable,
      input  first_load_or_replay, enhanced_mode_select,
      output data_output_bus, full_flag_n, almost_full_flag_n, empty_flag_n,
      output write_token_out_or_half_full, read_token_out_or_second_empty
   );
   modport host (
      output master_reset_n, wclk_en, rclk_en, wr_en_n, rd_en_n, data_in,
      output write_token_in_or_second_write_enable, read_token_in_or_second_read_enable,
      output first_load_or_replay, enhanced_mode_select,
      input  data_output_bus, full_flag_n, almost_full_flag_n, empty_flag_n,
      input  write_token_out_or_half_full, read_token_out_or_second_empty
   );
endinterface : fft_link_if

// [rtl/fft_device.sv]
// FIFO device end: grouping mode, storage, status flags and cascade tokens
// Functional notes
// - Latch grouping mode at master reset
// - Standalone needs both expansion inputs low; the code also picks it with one input high when that is not parallel
// - Parallel: second enables wired to partner flags
// - Cascade ring; first-load low means master
// - Reset drives both token outputs high
// - Output words 18 bits, unused bits zero
// - Full low at depth occupancy
// - Writes ignored while full is low
// - Full updated only on write beats
// - Almost-full from pointer difference against offset
// - Offset resets to depth/8 minus one
// - Almost-full low after depth minus offset writes
// - Standard almost-full falls on write, rises read
// - Enhanced bit 4: almost-full write-synchronous
// - Shared pin: half-full standalone, token cascaded
// - Token inputs form a closed ring
// - Last location written: token pulse, stop writing
// - Token received: become write-active next beat
// - No half-full indication when cascaded
// - Half-full low above half depth
// - Standard half-full falls on write, rises read
// - Enhanced bits 3..2 pick half-full clock side
// - Enhanced reset sets control bits 0..5
//
// Implementation choices: the APB slave port and the register addresses.
module fft_device
   import fft_pkg::*;
#(
   parameter int DEPTH = FFT_DEPTH
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   fft_link_if.dev               link,
   input  wire logic             cfg_load,
   input  wire logic [FFT_DW-1:0] cfg_offset_p,
   input  wire fft_pkg::fft_ctrl_t cfg_ctrl,
   input  wire logic             show_offset,
   output fft_pkg::fft_group_e   grouping_mode,
   output logic                  write_active,
   output logic                  read_active
);
   import fft_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C   = (AW+1)'(DEPTH);
   localparam logic [AW:0] HALF_C    = (AW+1)'(DEPTH / 2);
   localparam logic [AW:0] P_DEF     = (AW+1)'(DEPTH / 8 - 1);
   localparam logic [AW-1:0] LAST_IX = AW'(DEPTH - 1);

   //////////////////////////////////////////////////////////////////////////
   function automatic logic [AW:0] fill(input logic [AW:0] w, input logic [AW:0] r);
      fill = w - r;
   endfunction : fill

   function automatic fft_group_e decode_group(input logic write_token_in, input logic read_token_in,
                                               input logic fl, input logic enhanced_mode_select_n);
      if (write_token_in && read_token_in)
         decode_group = fl ? FFT_SLAVE : FFT_MASTER;
      else if (write_token_in && !enhanced_mode_select_n)
         decode_group = FFT_PARALLEL;
      else
         decode_group = FFT_STANDALONE;
   endfunction : decode_group

   //////////////////////////////////////////////////////////////////////////
   fft_group_e          grp_r;
   logic                enh_r;
   fft_ctrl_t           ctrl_r;
   logic [AW:0]         p_r;
   logic [AW:0]         wr_ptr_r;
   logic [AW:0]         rd_ptr_r;
   fft_word_t           mem_r [DEPTH];
   fft_word_t           dout_r;
   logic                full_n_r;
   logic                empty_n_r;
   logic                paf_n_r;
   logic                hf_n_r;
   logic                wpin_r;
   logic                rpin_r;
   logic                wact_r;
   logic                ract_r;
   logic                casc;
   logic                do_wr;
   logic                do_rd;
   logic [AW:0]         occ_nxt;
   logic                af_hit;
   logic                hf_hit;
   logic                mrst;
   fft_group_e          grp_in;

   assign mrst    = !link.master_reset_n;
   assign casc    = (grp_r == FFT_MASTER) || (grp_r == FFT_SLAVE);
   assign grp_in  = decode_group(link.write_token_in_or_second_write_enable,
                                 link.read_token_in_or_second_read_enable,
                                 link.first_load_or_replay, link.enhanced_mode_select);
   // paralleled partner gates each side through the second enables
   assign do_wr   = link.wclk_en && !link.wr_en_n && full_n_r && wact_r &&
                    (grp_r != FFT_PARALLEL || link.write_token_in_or_second_write_enable);
   assign do_rd   = link.rclk_en && !link.rd_en_n && empty_n_r && ract_r &&
                    (grp_r != FFT_PARALLEL || link.read_token_in_or_second_read_enable);
   assign occ_nxt = fill(wr_ptr_r + (AW+1)'(do_wr), rd_ptr_r + (AW+1)'(do_rd));
   // offset compare on modular pointer difference
   // low once occupancy reaches depth minus p
   assign af_hit  = ({1'b0, occ_nxt} + {1'b0, p_r}) >= {1'b0, DEPTH_C};
   assign hf_hit  = occ_nxt > HALF_C;

   //////////////////////////////////////////////////////////////////////////
   // Mode and configuration; the straps are caught by a clocked process
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grp_r  <= FFT_STANDALONE;
         enh_r  <= 1'b0;
         ctrl_r <= '0;
         p_r    <= P_DEF;
      end else if (mrst) begin
         grp_r  <= grp_in;
         enh_r  <= !link.enhanced_mode_select;
         ctrl_r <= link.enhanced_mode_select ? '0 : FFT_CTRL_W'({FFT_ENH_BITS{1'b1}});
         p_r    <= P_DEF;
      end else if (cfg_load) begin
         p_r    <= cfg_offset_p[AW:0];
         if (enh_r)
            ctrl_r <= cfg_ctrl;
      end
   end

   // Storage and pointers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else if (mrst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (do_wr)
            wr_ptr_r <= wr_ptr_r + 1'b1;
         if (do_rd)
            rd_ptr_r <= rd_ptr_r + 1'b1;
      end
   end

   always_ff @(posedge pclk) begin
      if (do_wr)
         mem_r[wr_ptr_r[AW-1:0]] <= link.data_in;
   end

   // data and zero-filled offset words on the output bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         dout_r <= '0;
      else if (mrst)
         dout_r <= '0;
      else if (do_rd)
         dout_r <= mem_r[rd_ptr_r[AW-1:0]];
      else if (show_offset)
         dout_r <= FFT_DW'(p_r);
   end

   //////////////////////////////////////////////////////////////////////////
   // Full and empty flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         full_n_r  <= 1'b1;
         empty_n_r <= 1'b0;
      end else if (mrst) begin
         full_n_r  <= 1'b1;
         empty_n_r <= 1'b0;
      end else begin
         // full refreshed on write beats only
         if (link.wclk_en)
            full_n_r <= occ_nxt != DEPTH_C;
         if (link.rclk_en)
            empty_n_r <= occ_nxt != '0;
      end
   end

   // Almost-full flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         paf_n_r <= 1'b1;
      else if (mrst)
         paf_n_r <= 1'b1;
      else if (enh_r && ctrl_r[FFT_CB_PAF]) begin
         if (link.wclk_en)
            paf_n_r <= !af_hit;
      end else begin
         // falls on write beat, rises on read beat
         if (link.wclk_en && af_hit)
            paf_n_r <= 1'b0;
         else if (link.rclk_en && !af_hit)
            paf_n_r <= 1'b1;
      end
   end

   // Half-full flag; bit 2 enables sync, bit 3 picks the read side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         hf_n_r <= 1'b1;
      else if (mrst)
         hf_n_r <= 1'b1;
      else if (enh_r && ctrl_r[FFT_CB_HF_LO]) begin
         if (ctrl_r[FFT_CB_HF_HI] ? link.rclk_en : link.wclk_en)
            hf_n_r <= !hf_hit;
      end else begin
         // falls on write beat, rises on read beat
         if (link.wclk_en && hf_hit)
            hf_n_r <= 1'b0;
         else if (link.rclk_en && !hf_hit)
            hf_n_r <= 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Write token and shared write-side pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wpin_r <= 1'b1;
         wact_r <= 1'b1;
      end else if (mrst) begin
         wpin_r <= 1'b1;
         wact_r <= grp_in != FFT_SLAVE;
      end else if (casc) begin
         // pin carries the token, never half-full
         if (link.wclk_en) begin
            // one-beat low pulse after last location
            wpin_r <= !(do_wr && wr_ptr_r[AW-1:0] == LAST_IX);
            // token from the previous device activates
            if (!link.write_token_in_or_second_write_enable)
               wact_r <= 1'b1;
            else if (do_wr && wr_ptr_r[AW-1:0] == LAST_IX)
               wact_r <= 1'b0;
         end
      end else begin
         wpin_r <= hf_n_r;
         wact_r <= 1'b1;
      end
   end

   // Read token mirrors the write side; paralleled shows a second empty
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rpin_r <= 1'b1;
         ract_r <= 1'b1;
      end else if (mrst) begin
         rpin_r <= 1'b1;
         ract_r <= grp_in != FFT_SLAVE;
      end else if (casc) begin
         if (link.rclk_en) begin
            rpin_r <= !(do_rd && rd_ptr_r[AW-1:0] == LAST_IX);
            if (!link.read_token_in_or_second_read_enable)
               ract_r <= 1'b1;
            else if (do_rd && rd_ptr_r[AW-1:0] == LAST_IX)
               ract_r <= 1'b0;
         end
      end else begin
         rpin_r <= (grp_r == FFT_PARALLEL) ? empty_n_r : 1'b1;
         ract_r <= 1'b1;
      end
   end

   assign link.data_output_bus                = dout_r;
   assign link.full_flag_n                    = full_n_r;
   assign link.almost_full_flag_n             = paf_n_r;
   assign link.empty_flag_n                   = empty_n_r;
   assign link.write_token_out_or_half_full   = wpin_r;
   assign link.read_token_out_or_second_empty = rpin_r;
   assign grouping_mode                       = grp_r;
   assign write_active                        = wact_r;
   assign read_active                         = ract_r;
endmodule : fft_device

// [rtl/fft_host.sv]
// System end: APB-programmed driver of the FIFO pins and status mirror
module fft_host
   import fft_pkg::*;
#(
   parameter int WDIV = FFT_WDIV,
   parameter int RDIV = FFT_RDIV
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   fft_link_if.host         link
);
   import fft_pkg::*;

   logic [FFT_C_W-1:0] ctrl_r;
   fft_word_t          wdata_r;
   fft_word_t          rdata_r;
   logic               wpend_r;
   logic               rpend_r;
   logic               rcap_r;
   logic [7:0]         wdiv_r;
   logic [7:0]         rdiv_r;
   logic               wen_r;
   logic               ren_r;
   logic [31:0]        prdata_r;
   logic               pslverr_r;
   logic               pready_r;
   logic               setup;
   logic               wr_acc;
   logic               mapped;

   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign mapped = paddr == FFT_A_CTRL || paddr == FFT_A_WDATA ||
                   paddr == FFT_A_RDATA || paddr == FFT_A_STATUS;

   //////////////////////////////////////////////////////////////////////////
   // Beat dividers for the write and read sides
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdiv_r <= '0;
         rdiv_r <= '0;
         wen_r  <= 1'b0;
         ren_r  <= 1'b0;
      end else begin
         wen_r  <= wdiv_r == 8'(WDIV - 1);
         ren_r  <= rdiv_r == 8'(RDIV - 1);
         wdiv_r <= (wdiv_r == 8'(WDIV - 1)) ? '0 : wdiv_r + 1'b1;
         rdiv_r <= (rdiv_r == 8'(RDIV - 1)) ? '0 : rdiv_r + 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // APB slave: answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= '0;
         pslverr_r <= 1'b0;
         pready_r  <= 1'b0;
      end else begin
         pready_r <= 1'b1;
         if (setup) begin
            pslverr_r <= !mapped;
            unique case (paddr)
               FFT_A_CTRL:   prdata_r <= 32'(ctrl_r);
               FFT_A_WDATA:  prdata_r <= 32'(wdata_r);
               FFT_A_RDATA:  prdata_r <= 32'(rdata_r);
               FFT_A_STATUS: prdata_r <= 32'({rpend_r, wpend_r, link.read_token_out_or_second_empty,
                                              link.write_token_out_or_half_full, link.empty_flag_n,
                                              link.almost_full_flag_n, link.full_flag_n});
               default:      prdata_r <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r  <= '0;
         wdata_r <= '0;
      end else if (wr_acc) begin
         if (paddr == FFT_A_CTRL)
            ctrl_r <= pwdata[FFT_C_W-1:0];
         if (paddr == FFT_A_WDATA && !wpend_r)
            wdata_r <= pwdata[FFT_DW-1:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Write request held until a beat finds the device not full
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wpend_r <= 1'b0;
      else if (wen_r && wpend_r && link.full_flag_n)
         wpend_r <= 1'b0;
      else if (wr_acc && paddr == FFT_A_WDATA)
         wpend_r <= 1'b1;
   end

   // Read request; data lands on the bus one cycle after the read beat
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rpend_r <= 1'b0;
         rcap_r  <= 1'b0;
         rdata_r <= '0;
      end else begin
         rcap_r <= ren_r && rpend_r && link.empty_flag_n;
         if (rcap_r)
            rdata_r <= link.data_output_bus;
         if (ren_r && rpend_r && link.empty_flag_n)
            rpend_r <= 1'b0;
         else if (wr_acc && paddr == FFT_A_RDATA)
            rpend_r <= 1'b1;
      end
   end

   assign prdata                                     = prdata_r;
   assign pready                                     = pready_r;
   assign pslverr                                    = pslverr_r;
   assign link.master_reset_n                        = !ctrl_r[FFT_C_MRST];
   assign link.enhanced_mode_select                  = ctrl_r[FFT_C_ENHANCED_MODE_SELECT_N];
   assign link.first_load_or_replay                  = ctrl_r[FFT_C_FLOAD];
   // straps low for standalone; set by software for other groupings
   assign link.write_token_in_or_second_write_enable = ctrl_r[FFT_C_WXI];
   assign link.read_token_in_or_second_read_enable   = ctrl_r[FFT_C_RXI];
   assign link.wclk_en                               = wen_r;
   assign link.rclk_en                               = ren_r;
   assign link.wr_en_n                               = !wpend_r;
   assign link.rd_en_n                               = !rpend_r;
   assign link.data_in                               = wdata_r;
endmodule : fft_host

// [test/fft_flags_checker.sv]
// Concurrent checks on the pin link between the host end and the device end
module fft_flags_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic master_reset_n,
   input wire logic wclk_en,
   input wire logic rclk_en,
   input wire logic wr_en_n,
   input wire logic write_token_in_or_second_write_enable,
   input wire logic read_token_in_or_second_read_enable,
   input wire logic enhanced_mode_select,
   input wire logic full_flag_n,
   input wire logic almost_full_flag_n,
   input wire logic write_token_out_or_half_full,
   input wire logic read_token_out_or_second_empty
);
   timeunit 1ns;
   timeprecision 1ps;
   wire  write_token_out = write_token_out_or_half_full;
   wire  read_token_out = read_token_out_or_second_empty;
   logic casc_r;
   logic enh_r;
   logic par_r;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////
   // mirror latched grouping
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         casc_r <= 1'b0;
         enh_r  <= 1'b0;
         par_r  <= 1'b0;
      end else if (!master_reset_n) begin
         casc_r <= write_token_in_or_second_write_enable & read_token_in_or_second_read_enable;
         enh_r  <= ~enhanced_mode_select;
         par_r  <= write_token_in_or_second_write_enable & ~read_token_in_or_second_read_enable & ~enhanced_mode_select;
      end
   end
   ////////////////////////////////////////////////////////////
   // reset forces outputs
   chk_reset_outs: assert property (!master_reset_n |=> write_token_out && read_token_out && full_flag_n && almost_full_flag_n)
      else $error("outputs not high after master reset");
   chk_full_beat: assert property ($changed(full_flag_n) && $past(master_reset_n) |-> $past(wclk_en))
      else $error("full flag moved without write beat");
   chk_full_write: assert property ($fell(full_flag_n) |-> $past(wclk_en) && !$past(wr_en_n))
      else $error("full flag fell without a write");
   chk_paf_fall: assert property ($fell(almost_full_flag_n) |-> $past(wclk_en))
      else $error("almost-full fell without write beat");
   chk_paf_rise: assert property (!enh_r && $rose(almost_full_flag_n) |-> $past(rclk_en) || !$past(master_reset_n))
      else $error("almost-full rose without read beat");
   // half-full falls on writes; the shared pin copies the flag one cycle late
   chk_hf_fall: assert property (!casc_r && !enh_r && $fell(write_token_out) |-> $past(wclk_en, 2))
      else $error("half-full fell without write beat");
   chk_token_cause: assert property (casc_r && $fell(write_token_out) |-> $past(wclk_en))
      else $error("write token without write beat");
   // one beat, default divider of two
   chk_token_width: assert property (casc_r && $fell(write_token_out) |-> ##1 !write_token_out ##1 write_token_out)
      else $error("write token width wrong");
   chk_rxo_idle: assert property (!casc_r && !par_r |-> read_token_out)
      else $error("read token low outside cascade");
endmodule : fft_flags_checker

// [test/fifo_flags_and_cascade_tokens_bench.sv]
// Self-checking bench: APB host end driving the FIFO device end over the pin link
module fifo_flags_and_cascade_tokens_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import fft_pkg::*;
   // Small depth keeps fills short
   localparam int DEPTH = 64;
   logic        pclk;
   logic        presetn;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        cfg_load;
   fft_word_t   cfg_offset_p;
   fft_ctrl_t   cfg_ctrl;
   logic        show_offset;
   fft_group_e  grouping_mode;
   logic        write_active;
   logic        read_active;
   logic [31:0] q;
   logic        err;
   int          fails = 0;
   int          num_checks = 0;
   int          seed = 32'h10C9;
   int          cyc = 0;
   int          tok_low = 0;
   int          tok_on = 0;
   int          p;
   fft_word_t   mq[$];
   logic [4:0]  strap [5] = '{5'h02, 5'h0A, 5'h08, 5'h1A, 5'h1E};
   fft_group_e  gexp [5] = '{FFT_STANDALONE, FFT_STANDALONE, FFT_PARALLEL, FFT_MASTER, FFT_SLAVE};
   fft_link_if  link ();
   fft_host fft_host_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .link);
   fft_device #(.DEPTH(DEPTH)) fft_device_inst (.pclk, .presetn, .link, .cfg_load, .cfg_offset_p, .cfg_ctrl,
      .show_offset, .grouping_mode, .write_active, .read_active);
   fft_flags_checker fft_flags_checker_inst (.pclk, .presetn, .master_reset_n(link.master_reset_n),
      .wclk_en(link.wclk_en), .rclk_en(link.rclk_en), .wr_en_n(link.wr_en_n),
      .write_token_in_or_second_write_enable(link.write_token_in_or_second_write_enable),
      .read_token_in_or_second_read_enable(link.read_token_in_or_second_read_enable),
      .enhanced_mode_select(link.enhanced_mode_select), .full_flag_n(link.full_flag_n),
      .almost_full_flag_n(link.almost_full_flag_n), .write_token_out_or_half_full(link.write_token_out_or_half_full),
      .read_token_out_or_second_empty(link.read_token_out_or_second_empty));
   ////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // Write-token pulse length seen on the shared pin
   always @(posedge pclk) begin
      cyc++;
      if (tok_on != 0 && link.write_token_out_or_half_full === 1'b0)
         tok_low++;
      if (cyc == 40000) begin
         fails++;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q       = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Queue a transfer; bounded poll, since a refused write may stay pending
   task automatic req(input logic [7:0] a, input fft_word_t d, input int b);
      int n;
      n = 0;
      apb(1'b1, a, {14'h0, d});
      do begin
         apb(1'b0, FFT_A_STATUS, 32'h0);
         n++;
      end while (q[b] === 1'b1 && n < 8);
      repeat (4) @(posedge pclk);
   endtask : req
   task automatic stat(input logic [4:0] m, input logic casc);
      int         o;
      logic [4:0] e;
      o = mq.size();
      e = {1'b1, casc || o <= DEPTH / 2, o > 0, o < DEPTH - p, o < DEPTH};
      apb(1'b0, FFT_A_STATUS, 32'h0);
      check("status", q[4:0] & m, e & m);
   endtask : stat
   task automatic mrst(input logic [4:0] s, input fft_group_e g);
      apb(1'b1, FFT_A_CTRL, {27'h0, s | 5'h01});
      apb(1'b1, FFT_A_CTRL, {27'h0, s});
      repeat (2) @(posedge pclk);
      mq.delete();
      check("grouping", grouping_mode, g);
      apb(1'b0, FFT_A_STATUS, 32'h0);
      check("reset flags", q[3:0], 4'hB);
   endtask : mrst
   task automatic fill(input int n, input logic [4:0] m, input logic casc);
      fft_word_t d;
      repeat (n) begin
         d = fft_word_t'($random(seed));
         req(FFT_A_WDATA, d, 5);
         mq.push_back(d);
         stat(m, casc);
      end
   endtask : fill
   task automatic drain(input int n, input logic casc);
      repeat (n) begin
         req(FFT_A_RDATA, 18'h0, 6);
         apb(1'b0, FFT_A_RDATA, 32'h0);
         check("read word", q, {14'h0, mq.pop_front()});
         stat(5'h0F, casc);
      end
   endtask : drain
   ////////////////////////////////////////////////////////////
   initial begin
      presetn      = 1'b0;
      psel         = 1'b0;
      penable      = 1'b0;
      pwrite       = 1'b0;
      paddr        = 8'h00;
      pwdata       = 32'h0;
      cfg_load     = 1'b0;
      cfg_offset_p = 18'h0;
      cfg_ctrl     = 12'h000;
      show_offset  = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      foreach (strap[i])
         mrst(strap[i], gexp[i]);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped error", err, 1'b1);
      mrst(5'h02, FFT_STANDALONE);
      p = DEPTH / 8 - 1;
      fill(DEPTH, 5'h1F, 1'b0);
      req(FFT_A_WDATA, 18'h0ABCD, 5);
      stat(5'h1F, 1'b0);
      mq.push_back(18'h0ABCD);
      drain(DEPTH + 1, 1'b0);
      mrst(5'h1A, FFT_MASTER);
      tok_on = 1;
      fill(DEPTH, 5'h1F, 1'b1);
      check("token beats", tok_low, FFT_WDIV);
      check("master write active", write_active, 1'b0);
      req(FFT_A_WDATA, 18'h2AAAA, 5);
      drain(1, 1'b1);
      tok_on = 0;
      mrst(5'h1E, FFT_SLAVE);
      check("slave idle", write_active, 1'b0);
      check("slave read idle", read_active, 1'b0);
      req(FFT_A_WDATA, 18'h15555, 5);
      stat(5'h04, 1'b1);
      apb(1'b1, FFT_A_CTRL, 32'h16);
      apb(1'b1, FFT_A_CTRL, 32'h1E);
      repeat (4) @(posedge pclk);
      check("slave active", write_active, 1'b1);
      fill(1, 5'h04, 1'b1);
      mrst(5'h08, FFT_PARALLEL);
      p = 1 + (($random(seed) & 32'h7FFFFFFF) % 20);
      @(posedge pclk);
      cfg_offset_p <= fft_word_t'(p);
      cfg_ctrl     <= 12'h03F;
      cfg_load     <= 1'b1;
      @(posedge pclk);
      cfg_load     <= 1'b0;
      show_offset  <= 1'b1;
      @(posedge pclk);
      show_offset  <= 1'b0;
      #1;
      check("offset word", link.data_output_bus, p);
      fill(DEPTH - p, 5'h03, 1'b0);
      end_sim();
   end
endmodule : fifo_flags_and_cascade_tokens_bench
